/* rtl/iar_defs.svh */
`ifndef IAR_DEFS_SVH
`define IAR_DEFS_SVH

// Main map
`define IAR_CTL_ADDR  8'hB0
`define IAR_OFS_ADDR  8'hB1
`define IAR_DAT_ADDR  8'hB2
`define IAR_RSV_FA    8'hFA
`define IAR_RSV_FB    8'hFB
`define IAR_CTL_RST   8'h00
`define IAR_SEL_HI    5
`define IAR_SEL_LO    2
`define IAR_AUTO_BIT  1

// Bank selector codes
`define IAR_SEL_PG0   4'h0
`define IAR_SEL_CH0   4'h1
`define IAR_SEL_CH1   4'h2
`define IAR_SEL_SHR   4'h5
`define IAR_SEL_BC    4'h6
`define IAR_SEL_CSI   4'h7

// Page 0 pattern registers
`define IAR_PG_CTL    8'h01
`define IAR_PG_CFG    8'h02
`define IAR_PG_DI     8'h03
`define IAR_PG_CTL_RST 8'h00
`define IAR_PG_CFG_RST 8'h33
`define IAR_PG_DI_RST  8'h24
`define IAR_EN_BIT    0
`define IAR_FIX_BIT   7
`define IAR_NCB_HI    5
`define IAR_NCB_LO    4
`define IAR_BSZ_HI    3
`define IAR_BSZ_LO    0
`define IAR_VC_HI     7
`define IAR_VC_LO     6
`define IAR_DT_HI     5
`define IAR_DT_LO     0

// Test register banks
`define IAR_CH_LAST   8'h14
`define IAR_SHR_LAST  8'h04
`define IAR_CSI_LAST  8'h1D
`define IAR_CH_N      21
`define IAR_SHR_N     5
`define IAR_CSI_N     30
`define IAR_LINKS     2

`endif

/* rtl/iar_pkg.sv */
package iar_pkg;

  typedef enum logic [2:0] {
    IAR_IDLE,
    IAR_ADDR,
    IAR_AACK,
    IAR_WBYTE,
    IAR_WACK,
    IAR_RBYTE,
    IAR_RACK
  } iar_fsm_e;

  typedef struct packed {
    logic [2:0] scl_sy;
    logic [2:0] sda_sy;
    logic       scl_f;
    logic       sda_f;
    iar_fsm_e   st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic       rw;
    logic       first;
    logic       sda_oe;
    logic [7:0] ptr;
    logic [7:0] ctl;
    logic [7:0] ofs;
    logic       ia_wr;
    logic [7:0] ia_wd;
  } iar_top_s;

  typedef struct packed {
    logic [7:0]                   pg_ctl;
    logic [7:0]                   pg_cfg;
    logic [7:0]                   pg_di;
    logic [1:0][20:0][7:0]        ch;
    logic [4:0][7:0]              shr;
    logic [29:0][7:0]             csi;
  } iar_bank_s;

endpackage

/* rtl/iar_ia_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface iar_ia_if;
  logic [3:0] sel;
  logic [7:0] ofs;
  logic       wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctl  (output sel, ofs, wr, wdata, input rdata);
  modport bank (input sel, ofs, wr, wdata, output rdata);
endinterface
`default_nettype wire

/* rtl/iar_bank.sv */
`timescale 1ns/100ps
`default_nettype none
`include "iar_defs.svh"
module iar_bank (
  input  wire logic       clk_in,     // Register clock
  input  wire logic       resetn_in,  // Async reset, active low
  iar_ia_if.bank          ia,         // Indirect access port
  output logic            pgen_on_out,    // Generator enable
  output logic            fixed_out,      // Fixed color choice
  output logic [1:0]      ncb_out,        // Color bar count code
  output logic [3:0]      bsz_out,        // Fixed block size
  output logic [1:0]      vc_out,         // Virtual channel
  output logic [5:0]      dt_out          // Data type
);
  localparam iar_pkg::iar_bank_s RST = '{pg_ctl: `IAR_PG_CTL_RST,
    pg_cfg: `IAR_PG_CFG_RST, pg_di: `IAR_PG_DI_RST, default: '0};

  iar_pkg::iar_bank_s r;
  iar_pkg::iar_bank_s n;
  logic [4:0]         ofs_lo;

  function automatic logic hit(input logic [7:0] o, input logic [7:0] last);
    return o <= last;
  endfunction

  assign ofs_lo = ia.ofs[4:0];

  always_comb begin
    n = r;
    ia.rdata = 8'h00;
    case (ia.sel)
      `IAR_SEL_PG0: begin
        if (ia.ofs == `IAR_PG_CTL) ia.rdata = r.pg_ctl;
        if (ia.ofs == `IAR_PG_CFG) ia.rdata = r.pg_cfg;
        if (ia.ofs == `IAR_PG_DI) ia.rdata = r.pg_di;
        if (ia.wr && ia.ofs == `IAR_PG_CTL) n.pg_ctl = ia.wdata;
        if (ia.wr && ia.ofs == `IAR_PG_CFG) n.pg_cfg = ia.wdata;
        if (ia.wr && ia.ofs == `IAR_PG_DI) n.pg_di = ia.wdata;
      end
      `IAR_SEL_CH0, `IAR_SEL_CH1: begin
        if (hit(ia.ofs, `IAR_CH_LAST)) begin
          ia.rdata = r.ch[ia.sel[1]][ofs_lo];
          if (ia.wr) n.ch[ia.sel[1]][ofs_lo] = ia.wdata;
        end
      end
      `IAR_SEL_SHR: begin
        if (hit(ia.ofs, `IAR_SHR_LAST)) begin
          ia.rdata = r.shr[ofs_lo[2:0]];
          if (ia.wr) n.shr[ofs_lo[2:0]] = ia.wdata;
        end
      end
      `IAR_SEL_BC: begin
        for (int i = 0; i < `IAR_LINKS; i++) begin
          if (ia.wr && hit(ia.ofs, `IAR_CH_LAST)) n.ch[i][ofs_lo] = ia.wdata;
        end
      end
      `IAR_SEL_CSI: begin
        if (hit(ia.ofs, `IAR_CSI_LAST)) begin
          ia.rdata = r.csi[ofs_lo];
          if (ia.wr) n.csi[ofs_lo] = ia.wdata;
        end
      end
      default: ia.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) r <= RST;
    else r <= n;
  end

  assign pgen_on_out = r.pg_ctl[`IAR_EN_BIT];
  assign fixed_out   = r.pg_cfg[`IAR_FIX_BIT];
  assign ncb_out     = r.pg_cfg[`IAR_NCB_HI:`IAR_NCB_LO];
  assign bsz_out     = r.pg_cfg[`IAR_BSZ_HI:`IAR_BSZ_LO];
  assign vc_out      = r.pg_di[`IAR_VC_HI:`IAR_VC_LO];
  assign dt_out      = r.pg_di[`IAR_DT_HI:`IAR_DT_LO];

  property p_pgen_on;
    @(posedge clk_in) disable iff (!resetn_in)
    ia.wr && ia.sel == `IAR_SEL_PG0 && ia.ofs == `IAR_PG_CTL
    |=> pgen_on_out == $past(ia.wdata[0]);
  endproperty
  a_pgen_on: assert property (p_pgen_on) else $error("enable bit");

  property p_fixed;
    @(posedge clk_in) disable iff (!resetn_in)
    ia.wr && ia.sel == `IAR_SEL_PG0 && ia.ofs == `IAR_PG_CFG
    |=> fixed_out == $past(ia.wdata[7]) && bsz_out == $past(ia.wdata[3:0]);
  endproperty
  a_fixed: assert property (p_fixed) else $error("cfg fields");

  property p_ncb;
    @(posedge clk_in) disable iff (!resetn_in)
    ia.wr && ia.sel == `IAR_SEL_PG0 && ia.ofs == `IAR_PG_CFG
    |=> ncb_out == $past(ia.wdata[5:4]);
  endproperty
  a_ncb: assert property (p_ncb) else $error("bar count");

  property p_dt;
    @(posedge clk_in) disable iff (!resetn_in)
    ia.wr && ia.sel == `IAR_SEL_PG0 && ia.ofs == `IAR_PG_DI
    |=> {vc_out, dt_out} == $past(ia.wdata);
  endproperty
  a_dt: assert property (p_dt) else $error("packet id");

  property p_rsvd;
    @(posedge clk_in) disable iff (!resetn_in)
    ia.sel == `IAR_SEL_PG0 && ia.ofs == 8'h00 |-> ia.rdata == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("page 0 reg 0");

  property p_bcast;
    @(posedge clk_in) disable iff (!resetn_in)
    ia.wr && ia.sel == `IAR_SEL_BC && ia.ofs <= `IAR_CH_LAST
    |=> r.ch[0][$past(ofs_lo)] == $past(ia.wdata)
     && r.ch[1][$past(ofs_lo)] == $past(ia.wdata);
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast");

  property p_res_bank;
    @(posedge clk_in) disable iff (!resetn_in)
    ia.sel == 4'h3 || ia.sel == 4'h4 || ia.sel > `IAR_SEL_CSI
    |-> ia.rdata == 8'h00;
  endproperty
  a_res_bank: assert property (p_res_bank) else $error("rsvd bank");
endmodule
`default_nettype wire

/* rtl/iar_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "iar_defs.svh"
module iar_top #(
  parameter logic [6:0] DEV_ADDR = 7'h3D  // Bus address, arbitrary
) (
  input  wire logic       clk_in,      // Register clock, 100 MHz
  input  wire logic       resetn_in,   // Async reset, active low
  input  wire logic       scl_in,      // I2C clock pin
  input  wire logic       sda_in,      // I2C data pin level
  output logic            sda_o_out,   // I2C data drive value
  output logic            sda_oe_out,  // I2C data pull-down enable
  output logic            pattern_generator_on_out,    // Generator on
  output logic            fixed_color_choice_out,      // Fixed pattern
  output logic [1:0]      color_bar_count_out,         // Bar count code
  output logic [3:0]      fixed_block_size_out,        // Block bytes
  output logic [1:0]      generated_virtual_channel_out, // VC id
  output logic [5:0]      generated_data_type_out        // Data type
);
  localparam iar_pkg::iar_top_s RST = '{scl_sy: 3'h7, sda_sy: 3'h7,
    scl_f: 1'b1, sda_f: 1'b1, st: iar_pkg::IAR_IDLE,
    ctl: `IAR_CTL_RST, default: '0};

  iar_pkg::iar_top_s r;
  iar_pkg::iar_top_s n;
  iar_ia_if          ia ();
  logic              scl_ok;
  logic              sda_ok;
  logic              scl_rise;
  logic              scl_fall;
  logic              sda_rise;
  logic              sda_fall;
  logic              auto_inc;
  logic [7:0]        rd_v;

  // Main map read decode
  function automatic logic [7:0] main_rd(input logic [7:0] a,
                                         input logic [7:0] c,
                                         input logic [7:0] o,
                                         input logic [7:0] d);
    logic [7:0] v;
    v = 8'h00;
    if (a == `IAR_CTL_ADDR) v = c;
    if (a == `IAR_OFS_ADDR) v = o;
    if (a == `IAR_DAT_ADDR) v = d;
    return v;
  endfunction

  // A pin change counts once the second and third stages agree
  assign scl_ok   = r.scl_sy[1] == r.scl_sy[2];
  assign sda_ok   = r.sda_sy[1] == r.sda_sy[2];
  assign scl_rise = scl_ok && r.scl_sy[2] && !r.scl_f;
  assign scl_fall = scl_ok && !r.scl_sy[2] && r.scl_f;
  assign sda_rise = sda_ok && r.sda_sy[2] && !r.sda_f;
  assign sda_fall = sda_ok && !r.sda_sy[2] && r.sda_f;
  assign auto_inc = r.ctl[`IAR_AUTO_BIT];
  assign rd_v     = main_rd(r.ptr, r.ctl, r.ofs, ia.rdata);

  always_comb begin
    logic load;
    logic wbyte;
    load  = 1'b0;
    wbyte = 1'b0;
    n = r;
    n.ia_wr = 1'b0;
    n.scl_sy = {r.scl_sy[1:0], scl_in};
    n.sda_sy = {r.sda_sy[1:0], sda_in};
    if (scl_ok) begin
      n.scl_f = r.scl_sy[2];
    end
    if (sda_ok) begin
      n.sda_f = r.sda_sy[2];
    end
    // Offset moves on the same clock edge at which the bank takes the write
    if (r.ia_wr && auto_inc) begin
      n.ofs = r.ofs + 8'h01;
    end
    if (sda_fall && r.scl_f) begin
      n.st = iar_pkg::IAR_ADDR;
      n.cnt = 4'h0;
      n.first = 1'b1;
      n.sda_oe = 1'b0;
    end else if (sda_rise && r.scl_f) begin
      n.st = iar_pkg::IAR_IDLE;
      n.sda_oe = 1'b0;
    end else begin
      unique case (r.st)
        iar_pkg::IAR_IDLE: begin
          n.sda_oe = 1'b0;
        end
        iar_pkg::IAR_ADDR: begin
          if (scl_rise) begin
            n.sh = {r.sh[6:0], r.sda_f};
            n.cnt = r.cnt + 4'h1;
          end else if (scl_fall && r.cnt == 4'h8) begin
            if (r.sh[7:1] == DEV_ADDR) begin
              n.sda_oe = 1'b1;
              n.rw = r.sh[0];
              n.st = iar_pkg::IAR_AACK;
            end else begin
              n.st = iar_pkg::IAR_IDLE;
            end
          end
        end
        iar_pkg::IAR_AACK: begin
          if (scl_fall) begin
            n.sda_oe = 1'b0;
            n.cnt = 4'h0;
            if (r.rw) begin
              load = 1'b1;
            end else begin
              n.st = iar_pkg::IAR_WBYTE;
            end
          end
        end
        iar_pkg::IAR_WBYTE: begin
          if (scl_rise) begin
            n.sh = {r.sh[6:0], r.sda_f};
            n.cnt = r.cnt + 4'h1;
          end else if (scl_fall && r.cnt == 4'h8) begin
            n.sda_oe = 1'b1;
            n.st = iar_pkg::IAR_WACK;
            n.first = 1'b0;
            if (r.first) begin
              n.ptr = r.sh;
            end else begin
              wbyte = 1'b1;
            end
          end
        end
        iar_pkg::IAR_WACK: begin
          if (scl_fall) begin
            n.sda_oe = 1'b0;
            n.cnt = 4'h0;
            n.st = iar_pkg::IAR_WBYTE;
          end
        end
        iar_pkg::IAR_RBYTE: begin
          if (scl_rise) begin
            n.cnt = r.cnt + 4'h1;
          end else if (scl_fall) begin
            if (r.cnt == 4'h8) begin
              n.sda_oe = 1'b0;
              n.st = iar_pkg::IAR_RACK;
            end else begin
              n.tx = {r.tx[6:0], 1'b0};
              n.sda_oe = !r.tx[6];
            end
          end
        end
        iar_pkg::IAR_RACK: begin
          if (scl_rise) begin
            n.rw = !r.sda_f;
          end else if (scl_fall) begin
            n.cnt = 4'h0;
            if (r.rw) begin
              load = 1'b1;
            end else begin
              n.st = iar_pkg::IAR_IDLE;
            end
          end
        end
        default: begin
          n.st = iar_pkg::IAR_IDLE;
        end
      endcase
    end
    if (load) begin
      n.rw = 1'b1;
      n.tx = rd_v;
      n.sda_oe = !rd_v[7];
      n.st = iar_pkg::IAR_RBYTE;
      n.ptr = r.ptr + 8'h01;
      if (r.ptr == `IAR_DAT_ADDR && auto_inc) begin
        n.ofs = r.ofs + 8'h01;
      end
    end
    if (wbyte) begin
      n.ptr = r.ptr + 8'h01;
      if (r.ptr == `IAR_CTL_ADDR) begin
        n.ctl = r.sh;
      end
      if (r.ptr == `IAR_OFS_ADDR) begin
        n.ofs = r.sh;
      end
      if (r.ptr == `IAR_DAT_ADDR) begin
        n.ia_wr = 1'b1;
        n.ia_wd = r.sh;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  assign ia.sel   = r.ctl[`IAR_SEL_HI:`IAR_SEL_LO];
  assign ia.ofs   = r.ofs;
  assign ia.wr    = r.ia_wr;
  assign ia.wdata = r.ia_wd;

  assign sda_o_out  = 1'b0;
  assign sda_oe_out = r.sda_oe;

  iar_bank u_bank (
    .clk_in      (clk_in),
    .resetn_in   (resetn_in),
    .ia          (ia.bank),
    .pgen_on_out (pattern_generator_on_out),
    .fixed_out   (fixed_color_choice_out),
    .ncb_out     (color_bar_count_out),
    .bsz_out     (fixed_block_size_out),
    .vc_out      (generated_virtual_channel_out),
    .dt_out      (generated_data_type_out)
  );

  property p_ctl_wr;
    @(posedge clk_in) disable iff (!resetn_in)
    r.st == iar_pkg::IAR_WBYTE && scl_fall && r.cnt == 4'h8 && !r.first
      && r.ptr == `IAR_CTL_ADDR
    |=> r.ctl == $past(r.sh)
    ##1 ia.sel == $past(r.sh[`IAR_SEL_HI:`IAR_SEL_LO], 2);
  endproperty
  a_ctl_wr: assert property (p_ctl_wr) else $error("ctl write");

  property p_auto_inc;
    @(posedge clk_in) disable iff (!resetn_in)
    r.ia_wr && auto_inc |=> r.ofs == $past(r.ofs) + 8'h01;
  endproperty
  a_auto_inc: assert property (p_auto_inc) else $error("auto inc");

  property p_no_inc;
    @(posedge clk_in) disable iff (!resetn_in)
    r.ia_wr && !auto_inc |=> r.ofs == $past(r.ofs);
  endproperty
  a_no_inc: assert property (p_no_inc) else $error("offset moved");

  property p_wrap;
    @(posedge clk_in) disable iff (!resetn_in)
    r.ia_wr && auto_inc && r.ofs == 8'hFF |=> r.ofs == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("offset wrap");

  property p_rsv_main;
    @(posedge clk_in) disable iff (!resetn_in)
    r.ptr == `IAR_RSV_FA || r.ptr == `IAR_RSV_FB |-> rd_v == 8'h00;
  endproperty
  a_rsv_main: assert property (p_rsv_main) else $error("FA/FB read");
endmodule
`default_nettype wire

/* verif/iar_host.sv */
`timescale 1ns/100ps
`default_nettype none
module iar_host (
  input  wire logic clk_in,     // Register clock
  input  wire logic sda_in,     // Resolved data wire level
  output var  logic scl_out,    // Bus clock, idles high
  output var  logic sda_oe_out  // High pulls the data wire low
);
  localparam int Q = 5;

  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // Data changes only while the clock is low, well past the answer delay
  task automatic bit_io(input logic low, output logic smp);
    tick(Q);
    sda_oe_out = low;
    tick(Q);
    scl_out = 1'b1;
    tick(Q);
    smp = sda_in;
    tick(Q);
    scl_out = 1'b0;
  endtask

  task automatic start();
    tick(Q);
    sda_oe_out = 1'b0;
    tick(Q);
    scl_out = 1'b1;
    tick(Q);
    sda_oe_out = 1'b1;
    tick(Q);
    scl_out = 1'b0;
  endtask

  task automatic stop();
    tick(Q);
    sda_oe_out = 1'b1;
    tick(Q);
    scl_out = 1'b1;
    tick(Q);
    sda_oe_out = 1'b0;
    tick(Q);
  endtask

  task automatic wbyte(input logic [7:0] b, inout logic ok);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(~b[i], s);
    end
    bit_io(1'b0, s);
    ok = ok & ~s;
  endtask

  // Pointer byte then one or two data bytes, MSB first
  task automatic write(input logic [6:0] a, input logic [7:0] p, d1, d2,
                       input bit two, output logic ok);
    ok = 1'b1;
    start();
    wbyte({a, 1'b0}, ok);
    wbyte(p, ok);
    wbyte(d1, ok);
    if (two) begin
      wbyte(d2, ok);
    end
    stop();
  endtask

  // Pointer set, repeated start, one byte read and refused with NACK
  task automatic read(input logic [6:0] a, input logic [7:0] p,
                      output logic [7:0] d, output logic ok);
    logic s;
    ok = 1'b1;
    start();
    wbyte({a, 1'b0}, ok);
    wbyte(p, ok);
    start();
    wbyte({a, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b0, d[i]);
    end
    bit_io(1'b0, s);
    stop();
  endtask
endmodule
`default_nettype wire

/* verif/iar_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module iar_top_tb;
  localparam logic [6:0] DEV = 7'h2A;  // Bus address, arbitrary
  localparam logic [3:0] CODE [6] = '{4'h1, 4'h2, 4'h5, 4'h7, 4'h3, 4'h4};
  localparam logic [7:0] LAST [6] = '{8'h14, 8'h14, 8'h04, 8'h1D, 8'h14,
                                      8'h14};
  logic       clk_in;
  logic       resetn_in;
  logic       scl;
  logic       hoe;
  logic       dut_oe;
  logic       dut_o;
  logic       sda;
  logic       on;
  logic       fx;
  logic [1:0] ncb;
  logic [3:0] bsz;
  logic [1:0] vc;
  logic [5:0] dt;
  logic [7:0] d;
  logic       ok;
  int         n_mismatch;
  int         checked;

  // Open drain: the device may only ever pull the wire low
  assign sda = ~hoe & (~dut_oe | dut_o);

  iar_top #(.DEV_ADDR(DEV)) i_dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .scl_in(scl), .sda_in(sda),
    .sda_o_out(dut_o), .sda_oe_out(dut_oe), .pattern_generator_on_out(on),
    .fixed_color_choice_out(fx), .color_bar_count_out(ncb),
    .fixed_block_size_out(bsz), .generated_virtual_channel_out(vc),
    .generated_data_type_out(dt));

  iar_host i_host (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
                   .sda_oe_out(hoe));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic cmp8(input string w, input logic [7:0] e, g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic cmp_ok(input string w, input logic e, g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", w, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] p, v);
    i_host.write(DEV, p, v, 8'h00, 1'b0, ok);
    cmp_ok("write ack", 1'b1, ok);
  endtask

  // Control then offset in one burst; the main pointer ends at 0xB2
  task automatic sel(input logic [3:0] s, input logic au,
                     input logic [7:0] o);
    i_host.write(DEV, 8'hB0, {2'b00, s, au, 1'b0}, o, 1'b1, ok);
    cmp_ok("select ack", 1'b1, ok);
  endtask

  task automatic rd(input logic [7:0] p, e);
    i_host.read(DEV, p, d, ok);
    cmp_ok("read ack", 1'b1, ok);
    cmp8($sformatf("reg %h", p), e, d);
  endtask

  task automatic chk_out(input logic [7:0] e1, e2);
    cmp8("pattern outputs", e1, {on, fx, ncb, bsz});
    cmp8("packet id outputs", e2, {vc, dt});
  endtask

  task automatic reset_dut();
    resetn_in = 1'b0;
    repeat (3) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    i_host.tick(3);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (95000) @(posedge clk_in);
    n_mismatch++;
    $display("ERROR run length expected end seen hang");
    results();
  end

  initial begin
    n_mismatch = 0;
    checked = 0;
    reset_dut();
    chk_out(8'h33, 8'h24);
    rd(8'hB0, 8'h00);
    sel(4'h0, 1'b1, 8'h00);
    rd(8'hB2, 8'h00);
    rd(8'hB2, 8'h00);
    rd(8'hB2, 8'h33);
    rd(8'hB2, 8'h24);
    rd(8'hB1, 8'h04);
    wr(8'hFA, 8'hFF);
    rd(8'hFA, 8'h00);
    rd(8'hFB, 8'h00);
    $display("test reset values done");
    sel(4'h0, 1'b1, 8'h00);
    wr(8'hB2, 8'hFF);
    wr(8'hB2, 8'h01);
    wr(8'hB2, 8'h9A);
    wr(8'hB2, 8'hC5);
    chk_out(8'hDA, 8'hC5);
    rd(8'hB1, 8'h04);
    sel(4'h0, 1'b0, 8'h00);
    rd(8'hB2, 8'h00);
    sel(4'h0, 1'b0, 8'h02);
    rd(8'hB2, 8'h9A);
    rd(8'hB1, 8'h02);
    sel(4'h0, 1'b0, 8'h01);
    wr(8'hB2, 8'h00);
    chk_out(8'h5A, 8'hC5);
    $display("test pattern registers done");
    for (int i = 0; i < 6; i++) begin
      sel(CODE[i], 1'b0, LAST[i]);
      wr(8'hB2, {CODE[i], 4'hA});
      rd(8'hB2, (i < 4) ? {CODE[i], 4'hA} : 8'h00);
      sel(CODE[i], 1'b0, LAST[i] + 8'h01);
      wr(8'hB2, 8'hFF);
      rd(8'hB2, 8'h00);
    end
    $display("test bank map done");
    sel(4'h6, 1'b0, 8'h14);
    wr(8'hB2, 8'h5A);
    rd(8'hB2, 8'h00);
    sel(4'h1, 1'b0, 8'h14);
    rd(8'hB2, 8'h5A);
    sel(4'h2, 1'b0, 8'h14);
    rd(8'hB2, 8'h5A);
    $display("test broadcast done");
    sel(4'h7, 1'b1, 8'h1C);
    wr(8'hB2, 8'h11);
    wr(8'hB2, 8'h22);
    wr(8'hB2, 8'h33);
    rd(8'hB1, 8'h1F);
    sel(4'h7, 1'b1, 8'h1C);
    rd(8'hB2, 8'h11);
    rd(8'hB2, 8'h22);
    rd(8'hB2, 8'h00);
    sel(4'h7, 1'b1, 8'hFF);
    wr(8'hB2, 8'h44);
    rd(8'hB1, 8'h00);
    $display("test auto increment done");
    i_host.write(DEV ^ 7'h01, 8'hB0, 8'h3C, 8'h00, 1'b0, ok);
    cmp_ok("foreign address ack", 1'b0, ok);
    rd(8'hB0, 8'h1E);
    $display("test foreign address done");
    reset_dut();
    chk_out(8'h33, 8'h24);
    rd(8'hB0, 8'h00);
    sel(4'h7, 1'b0, 8'h1C);
    rd(8'hB2, 8'h00);
    $display("test second reset done");
    results();
  end
endmodule
`default_nettype wire
